/* File: verilog/apf_map.vh */
// Constants of the alarm priority and failure handler
`ifndef APF_MAP_VH
`define APF_MAP_VH

// ------------------------------------------------------------
// Timebase
// ------------------------------------------------------------
`define APF_CLK_HZ 10000000
`define APF_TICK_S 1
`define APF_SEC_CYCLES (`APF_CLK_HZ * `APF_TICK_S)
`define APF_SEC_PER_MIN 6'h3C
`define APF_FAULT_DELAY_S 6'h3C
`define APF_REFRESH_MAX_MIN 8'hA0

// ------------------------------------------------------------
// Current loop limits and fallback values, microamps, percent, millivolts
// ------------------------------------------------------------
`define APF_LOOP_MIN_UA 16'h0FA0
`define APF_LOOP_MAX_UA 16'h4E20
`define APF_SUBST_HIGH 16'hFFFF
`define APF_LIMIT_PCT 7'h37
`define APF_FULL_PCT 7'h64
`define APF_AO_FAULT_MV 16'h04E2
`define APF_AO_FAULT_UA 16'h09C4

// ------------------------------------------------------------
// Alarm routing
// ------------------------------------------------------------
`define APF_NRELAY 5
`define APF_MODEM_BIT 5
`define APF_CODE_W 9
`define APF_MASK_W 6

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define APF_REG_CTRL 12'h000
`define APF_REG_STATUS 12'h004
`define APF_REG_EMERG 12'h008
`define APF_REG_PRIO_SEL 12'h00C
`define APF_REG_PRIO_DATA 12'h010
`define APF_REG_REFRESH0 12'h014

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define APF_CTRL_NREL_LSB 0
`define APF_CTRL_AOV_SEL 4
`define APF_CTRL_AOC_SEL 5
`define APF_CTRL_RESET 8
`define APF_CTRL_CLEAR_ALL 9
`define APF_CTRL_RST 3'h0
`define APF_EMERG_RST 8'h00
`define APF_REFRESH_RST 8'h00

`endif

/* File: verilog/apf_prio_mem.v */
// Priority mask table indexed by failure code
`timescale 1ns/1ps
module apf_prio_mem (
    // Clock
    input wire pclk,
    // Write port
    input wire wr_en,
    input wire [8:0] wr_addr,
    input wire [5:0] wr_data,
    // Read port, data registered
    input wire [8:0] rd_addr,
    output reg [5:0] rd_data
);
    reg [5:0] mem [0:511];
    integer i;

    // Table starts empty so no code is forwarded until assigned
    initial begin
        for (i = 0; i < 512; i = i + 1) begin
            mem[i] = 6'h00;
        end
    end

    always @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* File: verilog/apf_handler.v */
// Transmitter failure reactions and alarm relay routing
//
// Functional notes
// - Loop current outside 4-20 mA is failure
// - Suction failure: high stage input, 55% limit
// - Suction failure shows defect marker on display
// - High pressure failure: high fan input, 55%
// - High pressure failure suppresses condenser alarms
// - Failure of the input chosen by aov_sel or aoc_sel drives that analog output below range
// - Fault reactions wait 60 seconds of persistence
// - Emergency stages use inverted normally-closed relays
// - Configured count, up to five, of alarm relays
// - Mask levels 1-5 map relays, 6 modem
// - Empty priority mask forwards nothing
// - Relay energized when healthy, off until clear-all, or reset or refresh expiry if enabled
// - Repeat same-priority failure causes no relay transition
// - Per-relay refresh delay, 0 disables, max 160
// - Reset acts on all refresh-enabled relays
`include "apf_map.vh"
`timescale 1ns/1ps
module apf_handler #(
    parameter SEC_CYCLES = `APF_SEC_CYCLES
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Transmitters, 0 suction, 1 high pressure, microamps
    input wire [15:0] suct_loop_ua,
    input wire [15:0] hp_loop_ua,
    // Controller feeds
    output reg [15:0] suct_stage_in,
    output reg [15:0] fan_stage_in,
    output reg [6:0] comp_limit_pct,
    output reg [6:0] fan_limit_pct,
    output reg suct_display_defect,
    // Condenser pressure alarms per compound
    input wire [1:0] condenser_prealarm_in,
    input wire [1:0] condenser_alarm_in,
    output reg [1:0] condenser_prealarm,
    output reg [1:0] condenser_alarm,
    // Analog outputs
    input wire [15:0] ao_volt_mv_in,
    input wire [15:0] ao_curr_ua_in,
    output reg [15:0] ao_volt_mv,
    output reg [15:0] ao_curr_ua,
    // Compressor stages
    input wire [7:0] stage_req,
    output reg [7:0] stage_coil,
    // Failure events
    input wire fail_valid,
    input wire [8:0] fail_code,
    input wire reset_softkey,
    // Alarm outputs
    output reg [4:0] alarm_relay,
    output reg modem_req
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [2:0] relay_count;
    reg aov_sel;
    reg aoc_sel;
    reg [7:0] emerg_mask;
    reg [8:0] prio_sel;
    reg [7:0] refresh_min [0:4];
    reg cmd_reset;
    reg cmd_clear_all;
    wire [1:0] chan_raw;
    wire [1:0] chan_fail;
    reg [4:0] relay_sig;

    wire apb_acc = psel & penable & ~pready;
    wire apb_wr = apb_acc & pwrite;
    wire refresh_hit = (paddr >= `APF_REG_REFRESH0) && (paddr < `APF_REG_REFRESH0 + 12'h014) &&
        (paddr[1:0] == 2'b00);
    wire [2:0] refresh_idx = paddr[4:2] - 3'h5;
    wire mapped = (paddr == `APF_REG_CTRL) || (paddr == `APF_REG_STATUS) || (paddr == `APF_REG_EMERG) ||
        (paddr == `APF_REG_PRIO_SEL) || (paddr == `APF_REG_PRIO_DATA) || refresh_hit;
    wire prio_wr = apb_wr && (paddr == `APF_REG_PRIO_DATA);

    reg [31:0] next_rdata;
    integer k;

    always @* begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            `APF_REG_CTRL: next_rdata = {26'h0, aoc_sel, aov_sel, 1'b0, relay_count};
            `APF_REG_STATUS: next_rdata = {19'h0, relay_sig, 4'h0, chan_fail, chan_raw};
            `APF_REG_EMERG: next_rdata = {24'h0, emerg_mask};
            `APF_REG_PRIO_SEL: next_rdata = {23'h0, prio_sel};
            default: begin
                if (refresh_hit) begin
                    next_rdata = {24'h0, refresh_min[refresh_idx]};
                end
            end
        endcase
    end

    // One wait state on every access keeps pready a flop output
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            relay_count <= `APF_CTRL_RST;
            aov_sel <= 1'b0;
            aoc_sel <= 1'b0;
            emerg_mask <= `APF_EMERG_RST;
            prio_sel <= 9'h000;
            cmd_reset <= 1'b0;
            cmd_clear_all <= 1'b0;
            for (k = 0; k < 5; k = k + 1) begin
                refresh_min[k] <= `APF_REFRESH_RST;
            end
        end else begin
            pready <= apb_acc;
            pslverr <= apb_acc & ~mapped;
            cmd_reset <= 1'b0;
            cmd_clear_all <= 1'b0;
            if (apb_acc && !pwrite) begin
                prdata <= mapped ? next_rdata : 32'h0000_0000;
            end
            if (apb_wr) begin
                if (paddr == `APF_REG_CTRL) begin
                    // Counts above five saturate
                    relay_count <= (pwdata[2:0] > 3'h5) ? 3'h5 : pwdata[2:0];
                    aov_sel <= pwdata[`APF_CTRL_AOV_SEL];
                    aoc_sel <= pwdata[`APF_CTRL_AOC_SEL];
                    cmd_reset <= pwdata[`APF_CTRL_RESET];
                    cmd_clear_all <= pwdata[`APF_CTRL_CLEAR_ALL];
                end
                if (paddr == `APF_REG_EMERG) begin
                    emerg_mask <= pwdata[7:0];
                end
                if (paddr == `APF_REG_PRIO_SEL) begin
                    prio_sel <= pwdata[8:0];
                end
                if (refresh_hit) begin
                    refresh_min[refresh_idx] <= (pwdata[7:0] > `APF_REFRESH_MAX_MIN) ?
                        `APF_REFRESH_MAX_MIN : pwdata[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Timebase: second and minute enables
    // ------------------------------------------------------------
    reg [23:0] sec_div;
    reg [5:0] min_div;
    reg sec_tick;
    reg min_tick;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_div <= 24'h000000;
            min_div <= 6'h00;
            sec_tick <= 1'b0;
            min_tick <= 1'b0;
        end else begin
            sec_tick <= 1'b0;
            min_tick <= 1'b0;
            if (sec_div == SEC_CYCLES[23:0] - 24'h000001) begin
                sec_div <= 24'h000000;
                sec_tick <= 1'b1;
                if (min_div == `APF_SEC_PER_MIN - 6'h01) begin
                    min_div <= 6'h00;
                    min_tick <= 1'b1;
                end else begin
                    min_div <= min_div + 6'h01;
                end
            end else begin
                sec_div <= sec_div + 24'h000001;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter supervision
    // ------------------------------------------------------------
    wire [15:0] loop_ua [0:1];
    assign loop_ua[0] = suct_loop_ua;
    assign loop_ua[1] = hp_loop_ua;

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_chan
            reg [5:0] persist;
            reg failed;
            // Out of range on either side
            assign chan_raw[c] = (loop_ua[c] < `APF_LOOP_MIN_UA) || (loop_ua[c] > `APF_LOOP_MAX_UA);
            assign chan_fail[c] = failed;
            // Any return to range restarts the full delay
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    persist <= 6'h00;
                    failed <= 1'b0;
                end else if (!chan_raw[c]) begin
                    persist <= 6'h00;
                    failed <= 1'b0;
                end else if (sec_tick && !failed) begin
                    // First tick may be partial; one extra tick keeps the full delay
                    if (persist == `APF_FAULT_DELAY_S) begin
                        failed <= 1'b1;
                    end else begin
                        persist <= persist + 6'h01;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Failure reactions, all registered
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suct_stage_in <= 16'h0000;
            fan_stage_in <= 16'h0000;
            comp_limit_pct <= `APF_FULL_PCT;
            fan_limit_pct <= `APF_FULL_PCT;
            suct_display_defect <= 1'b0;
            condenser_prealarm <= 2'b00;
            condenser_alarm <= 2'b00;
            ao_volt_mv <= 16'h0000;
            ao_curr_ua <= 16'h0000;
            stage_coil <= 8'h00;
        end else begin
            suct_stage_in <= chan_fail[0] ? `APF_SUBST_HIGH : suct_loop_ua;
            comp_limit_pct <= chan_fail[0] ? `APF_LIMIT_PCT : `APF_FULL_PCT;
            suct_display_defect <= chan_fail[0];
            fan_stage_in <= chan_fail[1] ? `APF_SUBST_HIGH : hp_loop_ua;
            fan_limit_pct <= chan_fail[1] ? `APF_LIMIT_PCT : `APF_FULL_PCT;
            condenser_prealarm <= chan_fail[1] ? 2'b00 : condenser_prealarm_in;
            condenser_alarm <= chan_fail[1] ? 2'b00 : condenser_alarm_in;
            ao_volt_mv <= chan_fail[aov_sel] ? `APF_AO_FAULT_MV : ao_volt_mv_in;
            ao_curr_ua <= chan_fail[aoc_sel] ? `APF_AO_FAULT_UA : ao_curr_ua_in;
            // Unpowered NC contact closes, so emergency stages run
            stage_coil <= stage_req ^ emerg_mask;
        end
    end

    // ------------------------------------------------------------
    // Failure code lookup
    // ------------------------------------------------------------
    wire [5:0] code_mask;
    reg ev_valid;

    apf_prio_mem u_prio_mem (
        .pclk(pclk),
        .wr_en(prio_wr),
        .wr_addr(prio_sel),
        .wr_data(pwdata[5:0]),
        .rd_addr(fail_code),
        .rd_data(code_mask)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_valid <= 1'b0;
            modem_req <= 1'b0;
        end else begin
            ev_valid <= fail_valid;
            // Empty mask leaves the modem untouched
            modem_req <= ev_valid & code_mask[`APF_MODEM_BIT];
        end
    end

    // ------------------------------------------------------------
    // Alarm relays with refresh
    // ------------------------------------------------------------
    wire soft_reset = reset_softkey | cmd_reset;

    genvar r;
    generate
        for (r = 0; r < `APF_NRELAY; r = r + 1) begin : g_relay
            reg [7:0] age;
            wire reserved = (relay_count > r);
            wire refresh_on = (refresh_min[r] != 8'h00);
            wire hit = ev_valid & code_mask[r] & reserved;
            wire expire = relay_sig[r] & refresh_on & min_tick & (age == refresh_min[r] - 8'h01);
            wire clear = cmd_clear_all | (soft_reset & refresh_on) | expire;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    relay_sig[r] <= 1'b0;
                    age <= 8'h00;
                    alarm_relay[r] <= 1'b0;
                end else begin
                    // New failure wins over a clear in the same cycle
                    if (hit) begin
                        relay_sig[r] <= 1'b1;
                    end else if (clear || !reserved) begin
                        relay_sig[r] <= 1'b0;
                    end
                    if (!relay_sig[r] || hit || clear) begin
                        age <= 8'h00;
                    end else if (min_tick) begin
                        age <= age + 8'h01;
                    end
                    // Fail-safe: energized only while healthy
                    alarm_relay[r] <= reserved & ~(relay_sig[r] | hit);
                end
            end
        end
    endgenerate
endmodule

/* File: testbench/apf_monitor.sv */
// Port checker for the failure handler
`timescale 1ns/1ps
module apf_monitor #(
    parameter SEC_CYCLES = 10
) (
    // Clock, reset, bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    // Transmitter and controller feeds
    input wire logic [15:0] suct_loop_ua,
    input wire logic [15:0] suct_stage_in,
    input wire logic [15:0] fan_stage_in,
    input wire logic [6:0] comp_limit_pct,
    input wire logic [6:0] fan_limit_pct,
    input wire logic suct_display_defect,
    input wire logic [1:0] condenser_prealarm,
    input wire logic [1:0] condenser_alarm,
    // Analog outputs
    input wire logic [15:0] ao_volt_mv_in,
    input wire logic [15:0] ao_curr_ua_in,
    input wire logic [15:0] ao_volt_mv,
    input wire logic [15:0] ao_curr_ua,
    // Alarms
    input wire logic fail_valid,
    input wire logic [4:0] alarm_relay,
    input wire logic modem_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Out-of-range persistence counter
    // ----------------------------------------
    wire oor = suct_loop_ua < 16'h0FA0 || suct_loop_ua > 16'h4E20;
    logic [31:0] oor_cyc;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oor_cyc <= 32'h0;
        end else begin
            oor_cyc <= oor ? oor_cyc + 32'h1 : 32'h0;
        end
    end
    AST_FAIL_DELAY: assert property ($rose(suct_display_defect) |-> oor_cyc >= 60 * SEC_CYCLES)
        else $error("defect raised too early");
    AST_FAIL_DETECT: assert property (oor_cyc == 61 * SEC_CYCLES + 4 |-> suct_display_defect)
        else $error("defect missing after delay");
    AST_CLEAR: assert property (!oor [*2] |=> !suct_display_defect)
        else $error("defect while in range");
    AST_SUCT_FORCE: assert property (suct_display_defect |-> suct_stage_in == 16'hFFFF && comp_limit_pct == 7'h37)
        else $error("suction fallback wrong");
    AST_HP_FORCE: assert property (fan_limit_pct == 7'h37 |-> fan_stage_in == 16'hFFFF)
        else $error("fan fallback wrong");
    AST_COND_MUTE: assert property (fan_limit_pct == 7'h37 |-> condenser_prealarm == 2'b00 && condenser_alarm == 2'b00)
        else $error("condenser alarm not muted");
    AST_AO_LEVEL: assert property ($past(presetn) |-> (ao_volt_mv == $past(ao_volt_mv_in)
        || (ao_volt_mv >= 16'h03E8 && ao_volt_mv <= 16'h05DC)) && (ao_curr_ua == $past(ao_curr_ua_in)
        || (ao_curr_ua >= 16'h07D0 && ao_curr_ua <= 16'h0BB8)))
        else $error("analog output level wrong");
    AST_MODEM_CAUSE: assert property (modem_req |-> $past(fail_valid, 2))
        else $error("modem without event");
    AST_RELAY_FALL: assert property (($past(alarm_relay) & ~alarm_relay) != 5'h00 |->
        $past(fail_valid, 2) || $past(psel, 2) || $past(psel, 3))
        else $error("relay dropped without cause");
endmodule
bind apf_handler apf_monitor #(.SEC_CYCLES(SEC_CYCLES)) i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .suct_loop_ua(suct_loop_ua), .suct_stage_in(suct_stage_in), .fan_stage_in(fan_stage_in),
    .comp_limit_pct(comp_limit_pct), .fan_limit_pct(fan_limit_pct), .suct_display_defect(suct_display_defect),
    .condenser_prealarm(condenser_prealarm), .condenser_alarm(condenser_alarm), .ao_volt_mv_in(ao_volt_mv_in),
    .ao_curr_ua_in(ao_curr_ua_in), .ao_volt_mv(ao_volt_mv), .ao_curr_ua(ao_curr_ua),
    .fail_valid(fail_valid), .alarm_relay(alarm_relay), .modem_req(modem_req));

/* File: testbench/apf_relay_load.sv */
// Alarm relay load that counts de-energize events
`timescale 1ns/1ps
module apf_relay_load (
    // Clock
    input wire logic pclk,
    // Relay coils, high energized
    input wire logic [4:0] alarm_relay,
    // Drops per relay, 8 bits each
    output logic [39:0] drops
);
    logic [4:0] last = 5'h00;
    initial drops = 40'h0;
    // A drop is only a high-to-low edge; a relay held low counts once
    always @(posedge pclk) begin
        for (int i = 0; i < 5; i++) begin
            if (last[i] && !alarm_relay[i]) begin
                drops[i*8 +: 8] <= drops[i*8 +: 8] + 8'h01;
            end
        end
        last <= alarm_relay;
    end
endmodule

// ----------------------------------------
// Cold storage node on the data line
// ----------------------------------------
module apf_node_model #(
    parameter int MIN_CYCLES = 600
) (
    // Clock
    input wire logic pclk,
    // Data line state and received commands
    input wire logic link_up,
    input wire logic close_cmd,
    input wire logic compound_trip,
    // Node actuators, high active
    output logic valves_open,
    output logic fans_on,
    output logic defrost_allowed
);
    int lost = 0;
    logic close_held = 1'b0;
    initial begin
        valves_open = 1'b1;
        fans_on = 1'b1;
        defrost_allowed = 1'b1;
    end
    always @(posedge pclk) begin
        lost <= link_up ? 0 : lost + 1;
        // Last command stays in force for the first 30 minutes the line is down, then close is released
        if (link_up) begin
            close_held <= close_cmd;
        end else if (lost >= 30 * MIN_CYCLES) begin
            close_held <= 1'b0;
        end
        valves_open <= !compound_trip && !close_held;
        fans_on <= !compound_trip;
        defrost_allowed <= !compound_trip;
    end
endmodule

/* File: testbench/apf_handler_bench.sv */
// Self-checking bench for the failure handler
`include "apf_map.vh"
`timescale 1ns/1ps
module apf_handler_bench;
    typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] exp; logic err;} apf_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic sl, fail_valid = 1'b0, reset_softkey = 1'b0;
    logic [15:0] suct_loop_ua = 16'h0FA0, hp_loop_ua = 16'h4E20, ao_volt_mv_in = 16'h1388, ao_curr_ua_in = 16'h2EE0;
    logic [1:0] condenser_prealarm_in = 2'b11, condenser_alarm_in = 2'b11;
    logic [7:0] stage_req = 8'h00;
    logic [8:0] fail_code = 9'h000;
    wire [31:0] prdata;
    wire pready, pslverr, suct_display_defect, modem_req;
    wire [15:0] suct_stage_in, fan_stage_in, ao_volt_mv, ao_curr_ua;
    wire [6:0] comp_limit_pct, fan_limit_pct;
    wire [1:0] condenser_prealarm, condenser_alarm;
    wire [7:0] stage_coil;
    wire [4:0] alarm_relay;
    wire [39:0] drops;
    logic node_link = 1'b1, node_close = 1'b0, node_trip = 1'b0;
    wire node_valves, node_fans, node_defrost;
    int fail_count = 0, num_checks = 0, n;
    apf_row_t rows [10] = '{'{0, `APF_REG_CTRL, 0, 0, 0}, '{0, `APF_REG_EMERG, 0, 0, 0},
        '{0, 12'h024, 0, 0, 0}, '{1, `APF_REG_CTRL, 7, 0, 0}, '{0, `APF_REG_CTRL, 0, 5, 0},
        '{1, `APF_REG_REFRESH0, 200, 0, 0}, '{0, `APF_REG_REFRESH0, 0, 160, 0},
        '{0, `APF_REG_PRIO_DATA, 0, 0, 0}, '{1, 12'h100, 1, 0, 1}, '{0, 12'h100, 0, 0, 1}};
    always #50 pclk = ~pclk;
    apf_handler #(.SEC_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .suct_loop_ua(suct_loop_ua), .hp_loop_ua(hp_loop_ua), .suct_stage_in(suct_stage_in),
        .fan_stage_in(fan_stage_in), .comp_limit_pct(comp_limit_pct), .fan_limit_pct(fan_limit_pct),
        .suct_display_defect(suct_display_defect), .condenser_prealarm_in(condenser_prealarm_in),
        .condenser_alarm_in(condenser_alarm_in), .condenser_prealarm(condenser_prealarm),
        .condenser_alarm(condenser_alarm), .ao_volt_mv_in(ao_volt_mv_in), .ao_curr_ua_in(ao_curr_ua_in),
        .ao_volt_mv(ao_volt_mv), .ao_curr_ua(ao_curr_ua), .stage_req(stage_req), .stage_coil(stage_coil),
        .fail_valid(fail_valid), .fail_code(fail_code), .reset_softkey(reset_softkey),
        .alarm_relay(alarm_relay), .modem_req(modem_req));
    apf_relay_load i_load (.pclk(pclk), .alarm_relay(alarm_relay), .drops(drops));
    apf_node_model #(.MIN_CYCLES(2)) i_node (.pclk(pclk), .link_up(node_link), .close_cmd(node_close),
        .compound_trip(node_trip), .valves_open(node_valves), .fans_on(node_fans), .defrost_allowed(node_defrost));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait on the slave; only the watchdog ends a dead bus
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fire(input logic [8:0] c);
        @(posedge pclk);
        fail_valid <= 1'b1;
        fail_code <= c;
        @(posedge pclk);
        fail_valid <= 1'b0;
        // Modem request stands for this one cycle only
        @(posedge pclk);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        chk("limit in reset", 7'h64, comp_limit_pct);
        chk("relays in reset", 5'h00, alarm_relay);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk("slverr", rows[i].err, sl);
            if (!rows[i].wr) chk("read", rows[i].exp, rd);
        end
        #1;
        chk("relays idle", 5'h1F, alarm_relay);
        apb(1, `APF_REG_PRIO_SEL, 160);
        apb(1, `APF_REG_PRIO_DATA, 6'h25);
        apb(1, `APF_REG_PRIO_SEL, 300);
        apb(1, `APF_REG_PRIO_DATA, 0);
        apb(1, `APF_REG_REFRESH0, 1);
        fire(300);
        chk("empty mask", 6'h1F, {modem_req, alarm_relay});
        fire(160);
        chk("routed", 6'h3A, {modem_req, alarm_relay});
        fire(160);
        @(posedge pclk);
        #1;
        chk("repeat drop", 8'h01, drops[7:0]);
        @(posedge pclk);
        reset_softkey <= 1'b1;
        @(posedge pclk);
        reset_softkey <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        chk("after reset", 5'h1B, alarm_relay);
        fire(160);
        @(posedge pclk);
        #1;
        chk("second drop", 8'h02, drops[7:0]);
        n = 0;
        while (alarm_relay[0] !== 1'b1 && n < 700) begin
            @(posedge pclk);
            n++;
        end
        #1;
        chk("refresh time", 1, n <= 602);
        chk("refresh", 5'h1B, alarm_relay);
        apb(1, `APF_REG_CTRL, 32'h202);
        #1;
        chk("two relays", 5'h03, alarm_relay);
        fire(160);
        chk("two routed", 6'h22, {modem_req, alarm_relay});
        apb(1, `APF_REG_EMERG, 8'h81);
        stage_req <= 8'hFF;
        repeat (2) @(posedge pclk);
        #1;
        chk("coils", 8'h7E, stage_coil);
        chk("edge in range", 16'h4E20, fan_stage_in);
        apb(1, `APF_REG_CTRL, 32'h22);
        suct_loop_ua <= 16'h0F9F;
        hp_loop_ua <= 16'h4E21;
        repeat (580) @(posedge pclk);
        #1;
        chk("early", {1'b0, 7'h64, 7'h64}, {suct_display_defect, comp_limit_pct, fan_limit_pct});
        chk("early cond", 4'hF, {condenser_prealarm, condenser_alarm});
        repeat (40) @(posedge pclk);
        #1;
        chk("suct fail", {1'b1, 16'hFFFF, 7'h37}, {suct_display_defect, suct_stage_in, comp_limit_pct});
        chk("hp fail", {16'hFFFF, 7'h37}, {fan_stage_in, fan_limit_pct});
        chk("cond muted", 4'h0, {condenser_prealarm, condenser_alarm});
        chk("ao fault", {16'h04E2, 16'h09C4}, {ao_volt_mv, ao_curr_ua});
        apb(0, `APF_REG_STATUS, 0);
        chk("status", 32'h0000_000F, rd);
        suct_loop_ua <= 16'h2710;
        hp_loop_ua <= 16'h2710;
        repeat (3) @(posedge pclk);
        #1;
        chk("recovered", {1'b0, 7'h64, 16'h1388}, {suct_display_defect, fan_limit_pct, ao_volt_mv});
        @(posedge pclk);
        node_close <= 1'b1;
        @(posedge pclk);
        node_link <= 1'b0;
        repeat (30) @(posedge pclk);
        #1;
        chk("node holds close", 1'b0, node_valves);
        repeat (40) @(posedge pclk);
        #1;
        chk("node reverts", 1'b1, node_valves);
        @(posedge pclk);
        node_trip <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk("node trip", 3'b000, {node_valves, node_fans, node_defrost});
        wrap_up();
    end
endmodule
